// file: common/tbd_defines.svh
// Instruction field positions, widths and cycle timing constants
`ifndef TBD_DEFINES_SVH
`define TBD_DEFINES_SVH
`define TBD_INSN_W        12
`define TBD_FADDR_W       5
`define TBD_FADDR_MAX     7'h7F
`define TBD_BYTE_OP_HI    11
`define TBD_BYTE_OP_LO    6
`define TBD_DEST_BIT      5
`define TBD_FILE_HI       4
`define TBD_FILE_LO       0
`define TBD_BIT_OP_HI     11
`define TBD_BIT_OP_LO     8
`define TBD_BSEL_HI       7
`define TBD_BSEL_LO       5
`define TBD_LIT_OP_HI     11
`define TBD_LIT_OP_LO     8
`define TBD_LIT8_HI       7
`define TBD_JMP_OP_HI     11
`define TBD_JMP_OP_LO     9
`define TBD_LIT9_HI       8
`define TBD_QPHASES       4
`define TBD_DEST_ACC      1'b0
`define TBD_DEST_FILE     1'b1
// Opcode values of the top bits used for classification
`define TBD_CLS_BIT_LO    4'h4
`define TBD_CLS_BIT_HI    4'h7
`define TBD_JMP_OP        3'h5
`define TBD_CALL_OP       4'h9
`define TBD_RET_OP        4'h8
`define TBD_BTFSC_OP      4'h6
`define TBD_BTFSS_OP      4'h7
`define TBD_DECFSZ_OP     6'h0B
`define TBD_INCFSZ_OP     6'h0F
`define TBD_MOVWF_OP      7'h01
`define TBD_PCL_ADDR      5'h02
`endif

// file: common/tbd_pkg.sv
// Types shared by the instruction decode front end
package tbd_pkg;
	typedef enum logic [1:0]
	{
		TBD_CAT_BYTE,
		TBD_CAT_BIT,
		TBD_CAT_LIT
	} tbd_cat_t;
endpackage : tbd_pkg

// file: verilog/tbd_qphase.sv
// Four-phase instruction cycle generator
`timescale 1ns/1ps
`include "tbd_defines.svh"
module tbd_qphase #(
	parameter int PHASES = `TBD_QPHASES
) (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	// Phase outputs
	output logic [1:0]      phase_o,
	output logic            cyc_end_o
);
	logic [1:0] phase_q;
	logic [1:0] phase_d;

	// Wrap after the last oscillator period of the cycle
	assign phase_d   = (phase_q == 2'(PHASES - 1)) ? 2'h0 : phase_q + 2'h1;
	assign phase_o   = phase_q;
	assign cyc_end_o = (phase_q == 2'(PHASES - 1));

	// Phase counter runs freely from reset
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			phase_q <= 2'h0;
		else
			phase_q <= phase_d;
	end
endmodule : tbd_qphase

// file: verilog/tbd_decode.sv
// Instruction decode and cycle timing front end for a 12-bit word core
// Contract
// - Each instruction is one 12-bit word: opcode plus operand fields.
// - Three categories: byte-oriented, bit-oriented, literal and control.
// - Byte-oriented words name the file register through the file operand.
// - Destination bit 0 sends result to accumulator, 1 to file register.
// - Bit-oriented words select a bit of an 8-bit file register.
// - Literal words carry an 8-bit or 9-bit constant operand.
// - File address space spans 0x00 to 0x7F; decode zero-extends the 5-bit file field, so it reaches 0x00 to 0x1F only.
// - Instructions take one cycle unless a test succeeds or PC changes.
// - Taken tests and program counter changes take two cycles.
// - One instruction cycle is four oscillator periods.
// - Don't-care bits never affect decoding; tools should fill zero.
// - Byte words: opcode 11..6, destination bit 5, file 4..0.
// - Literal words: opcode 11..8, 8-bit constant 7..0.
// - Jump words: opcode 11..9, 9-bit target 8..0.
`timescale 1ns/1ps
`include "tbd_defines.svh"
module tbd_decode #(
	parameter int INSN_W = `TBD_INSN_W
) (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rstn_i,
	// Program memory word
	input  wire logic [INSN_W-1:0] insn_i,
	// Condition result from the execute stage for skip instructions
	input  wire logic              cond_true_i,
	// Decoded fields
	output tbd_pkg::tbd_cat_t      cat_o,
	output logic [5:0]             opcode_o,
	output logic [6:0]             faddr_o,
	output logic                   dest_file_o,
	output logic                   dest_acc_o,
	output logic [2:0]             bit_sel_o,
	output logic [7:0]             bit_mask_o,
	output logic [8:0]             literal_o,
	output logic                   lit9_o,
	// Timing
	output logic [1:0]             phase_o,
	output logic                   fetch_o,
	output logic                   second_cyc_o
);
	// Phase generator wires
	logic [1:0] phase_w;
	logic       cyc_end_w;

	tbd_qphase #(
		.PHASES (`TBD_QPHASES)
	) u_qphase (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.phase_o   (phase_w),
		.cyc_end_o (cyc_end_w)
	);

	// Field extraction straight from the word
	logic [5:0] byte_op_w;
	logic [3:0] top4_w;
	logic [2:0] top3_w;
	logic       dest_w;
	logic [4:0] file_w;
	logic [2:0] bsel_w;
	logic [7:0] lit8_w;
	logic [8:0] lit9_w;

	assign byte_op_w = insn_i[`TBD_BYTE_OP_HI:`TBD_BYTE_OP_LO];
	assign dest_w    = insn_i[`TBD_DEST_BIT];
	assign file_w    = insn_i[`TBD_FILE_HI:`TBD_FILE_LO];
	assign top4_w    = insn_i[`TBD_LIT_OP_HI:`TBD_LIT_OP_LO];
	assign bsel_w    = insn_i[`TBD_BSEL_HI:`TBD_BSEL_LO];
	assign lit8_w    = insn_i[`TBD_LIT8_HI:0];
	assign top3_w    = insn_i[`TBD_JMP_OP_HI:`TBD_JMP_OP_LO];
	assign lit9_w    = insn_i[`TBD_LIT9_HI:0];

	// Category split: top nibble 0..3 byte, 4..7 bit, rest literal/control
	logic is_bit_w;
	logic is_byte_w;
	logic is_jmp_w;
	tbd_pkg::tbd_cat_t cat_w;

	assign is_byte_w = (top4_w < `TBD_CLS_BIT_LO);
	assign is_bit_w  = (top4_w >= `TBD_CLS_BIT_LO) && (top4_w <= `TBD_CLS_BIT_HI);
	assign is_jmp_w  = (top3_w == `TBD_JMP_OP);
	assign cat_w     = is_byte_w ? tbd_pkg::TBD_CAT_BYTE :
		(is_bit_w ? tbd_pkg::TBD_CAT_BIT : tbd_pkg::TBD_CAT_LIT);

	// Opcode field width depends on the format; unused low bits forced zero
	logic [5:0] opcode_w;
	assign opcode_w = is_byte_w ? byte_op_w :
		(is_jmp_w ? {top3_w, 3'h0} : {top4_w, 2'h0});

	// File address zero-extended into the 0x00..0x7F space
	logic [6:0] faddr_w;
	assign faddr_w = {2'h0, file_w};

	// Literal operand, 9 bits only for the jump format
	logic [8:0] literal_w;
	assign literal_w = is_jmp_w ? lit9_w : {1'b0, lit8_w};

	// Bit mask of the selected position
	logic [7:0] mask_w;
	assign mask_w = 8'h01 << bsel_w;

	// Flow change detection: jumps, calls, returns, writes to the PC file
	logic pc_change_w;
	logic skip_op_w;
	logic long_w;
	logic pcl_dest_w;

	// Destination bit compared (whole opcode only for the MOVWF term), so accumulator-destination byte words on file 2 stay short
	assign pcl_dest_w  = is_byte_w && (file_w == `TBD_PCL_ADDR) &&
		(dest_w == `TBD_DEST_FILE || {byte_op_w, dest_w} == `TBD_MOVWF_OP);
	assign pc_change_w = is_jmp_w || (top4_w == `TBD_CALL_OP) ||
		(top4_w == `TBD_RET_OP) || pcl_dest_w;
	// Skip tests: the bit test pair plus both count-and-skip byte operations
	assign skip_op_w   = (top4_w == `TBD_BTFSC_OP) || (top4_w == `TBD_BTFSS_OP) ||
		(byte_op_w == `TBD_DECFSZ_OP) || (byte_op_w == `TBD_INCFSZ_OP);
	assign long_w      = pc_change_w || (skip_op_w && cond_true_i);

	// Instruction cycle state: a second cycle follows long instructions
	typedef enum logic
	{
		ST_FIRST,
		ST_SECOND
	} tbd_st_t;

	tbd_st_t st_q;
	tbd_st_t st_d;
	logic fetch_d;

	assign st_d    = !cyc_end_w ? st_q :
		((st_q == ST_FIRST && long_w) ? ST_SECOND : ST_FIRST);
	assign fetch_d = cyc_end_w && (st_d == ST_FIRST);

	// Cycle state advances only at the end of a four-period cycle
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_q <= ST_FIRST;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Registered outputs; fields latched at cycle end so they hold a whole cycle
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cat_o       <= tbd_pkg::TBD_CAT_BYTE;
			opcode_o    <= 6'h00;
			faddr_o     <= 7'h00;
			dest_file_o <= 1'b0;
			dest_acc_o  <= 1'b0;
			bit_sel_o   <= 3'h0;
			bit_mask_o  <= 8'h00;
			literal_o   <= 9'h000;
			lit9_o      <= 1'b0;
		end
		else if (cyc_end_w && st_q == ST_FIRST)
		begin
			cat_o       <= cat_w;
			opcode_o    <= opcode_w;
			faddr_o     <= (is_byte_w || is_bit_w) ? faddr_w : 7'h00;
			dest_file_o <= is_byte_w && (dest_w == `TBD_DEST_FILE);
			dest_acc_o  <= is_byte_w && (dest_w == `TBD_DEST_ACC);
			bit_sel_o   <= is_bit_w ? bsel_w : 3'h0;
			bit_mask_o  <= is_bit_w ? mask_w : 8'h00;
			literal_o   <= is_byte_w || is_bit_w ? 9'h000 : literal_w;
			lit9_o      <= is_jmp_w;
		end
	end

	// Timing outputs
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			phase_o      <= 2'h0;
			fetch_o      <= 1'b0;
			second_cyc_o <= 1'b0;
		end
		else
		begin
			phase_o      <= phase_w;
			fetch_o      <= fetch_d;
			second_cyc_o <= (st_d == ST_SECOND);
		end
	end
endmodule : tbd_decode

// file: dv/tbd_prog_mem.sv
// Program memory model that hands words to the decoder
`timescale 1ns/1ps
module tbd_prog_mem (
	// Clock, reset and fetch
	input  wire logic   sys_clk_i,
	input  wire logic   rstn_i,
	input  wire logic   fetch_i,
	// Instruction word
	output logic [11:0] insn_o
);
	logic [11:0] mem [0:15];
	logic [3:0]  addr_q;
	// Unwritten places decode as a harmless word, never as unknown
	initial
	begin
		foreach (mem[i])
			mem[i] = 12'hFFF;
	end
	// Step on the falling edge so the word stays put over phase 3
	always_ff @(negedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			addr_q <= 4'h0;
		else if (fetch_i)
			addr_q <= addr_q + 4'h1;
	end
	assign insn_o = mem[addr_q];
endmodule : tbd_prog_mem

// file: dv/tbd_decode_checker.sv
// Timing and field relations of the decode front end
`timescale 1ns/1ps
module tbd_decode_checker #(
	parameter int INSN_W = 12
) (
	// Design ports
	input wire logic              sys_clk_i,
	input wire logic              rstn_i,
	input wire logic [INSN_W-1:0] insn_i,
	input wire logic              cond_true_i,
	input tbd_pkg::tbd_cat_t      cat_o,
	input wire logic [5:0]        opcode_o,
	input wire logic [6:0]        faddr_o,
	input wire logic              dest_file_o,
	input wire logic              dest_acc_o,
	input wire logic [2:0]        bit_sel_o,
	input wire logic [7:0]        bit_mask_o,
	input wire logic [8:0]        literal_o,
	input wire logic              lit9_o,
	input wire logic [1:0]        phase_o,
	input wire logic              fetch_o,
	input wire logic              second_cyc_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// Second cycle closes four clocks later
	sequence s_long_end;
		(!fetch_o) [*3] ##1 (fetch_o && !second_cyc_o);
	endsequence
	a_fetch_gap: assert property (fetch_o |=> (!fetch_o) [*3])
		else $error("fetch pulses too close");
	a_long_end: assert property ($rose(second_cyc_o) |=> s_long_end)
		else $error("long instruction not two cycles");
	a_phase_step: assert property ($past(rstn_i, 2) |->
		phase_o == $past(phase_o) + 2'h1)
		else $error("phase did not advance");
	a_phase_fetch: assert property (fetch_o |-> phase_o == 2'h3)
		else $error("fetch off cycle end");
	a_dest_excl: assert property (!(dest_file_o && dest_acc_o))
		else $error("two destinations");
	a_dest_cat: assert property (dest_file_o || dest_acc_o |->
		cat_o == tbd_pkg::TBD_CAT_BYTE)
		else $error("destination outside byte word");
	a_mask_sel: assert property (bit_mask_o ==
		(cat_o == tbd_pkg::TBD_CAT_BIT ? 8'h01 << bit_sel_o : 8'h00))
		else $error("bit mask wrong");
	a_lit9_cat: assert property (lit9_o |->
		cat_o == tbd_pkg::TBD_CAT_LIT && opcode_o[2:0] == 3'h0)
		else $error("jump fields wrong");
	a_field_hold: assert property ($changed({opcode_o, literal_o}) |->
		fetch_o || second_cyc_o)
		else $error("fields changed mid cycle");
endmodule : tbd_decode_checker
bind tbd_decode tbd_decode_checker #(.INSN_W(INSN_W)) chk_i (.sys_clk_i(sys_clk_i),
	.rstn_i(rstn_i), .insn_i(insn_i), .cond_true_i(cond_true_i), .cat_o(cat_o),
	.opcode_o(opcode_o), .faddr_o(faddr_o), .dest_file_o(dest_file_o), .dest_acc_o(dest_acc_o),
	.bit_sel_o(bit_sel_o), .bit_mask_o(bit_mask_o), .literal_o(literal_o), .lit9_o(lit9_o),
	.phase_o(phase_o), .fetch_o(fetch_o), .second_cyc_o(second_cyc_o));

// file: dv/tbd_decode_tb.sv
// Self-checking bench of the decode front end fed by a program memory
`timescale 1ns/1ps
module tbd_decode_tb;
	logic              sys_clk_i = 1'b0;
	logic              rstn_i = 1'b0;
	logic              cond_true_i = 1'b0;
	logic [11:0]       insn_i;
	tbd_pkg::tbd_cat_t cat_o;
	logic [5:0]        opcode_o;
	logic [6:0]        faddr_o;
	logic [2:0]        bit_sel_o;
	logic [7:0]        bit_mask_o;
	logic [8:0]        literal_o;
	logic [1:0]        phase_o;
	logic              dest_file_o, dest_acc_o, lit9_o, fetch_o, second_cyc_o;
	int                error_cnt = 0;
	int                checks_done = 0;
	int                idx = 0;
	// Clock
	initial
	begin
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	tbd_prog_mem pm (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .fetch_i(fetch_o), .insn_o(insn_i));
	tbd_decode uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .insn_i(insn_i),
		.cond_true_i(cond_true_i), .cat_o(cat_o), .opcode_o(opcode_o), .faddr_o(faddr_o),
		.dest_file_o(dest_file_o), .dest_acc_o(dest_acc_o), .bit_sel_o(bit_sel_o),
		.bit_mask_o(bit_mask_o), .literal_o(literal_o), .lit9_o(lit9_o), .phase_o(phase_o),
		.fetch_o(fetch_o), .second_cyc_o(second_cyc_o));
	task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	// Load one word, wait for its cycle end, then judge fields and timing
	task automatic chk(input logic [11:0] w, input logic c, input logic lng);
		int n;
		logic jmp;
		logic [5:0] eop;
		jmp = w[11:9] == 3'h5;
		eop = !w[11:10] ? w[11:6] : jmp ? {w[11:9], 3'h0} : {w[11:8], 2'h0};
		pm.mem[idx] = w;
		idx++;
		cond_true_i = c;
		n = 0;
		do
		begin
			@(negedge sys_clk_i);
			n++;
		end
		while (!(fetch_o === 1'b1 || second_cyc_o === 1'b1) && n < 12);
		if (n >= 12)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: no cycle end seen", $time);
			conclude();
		end
		else
		begin
			cmp(cat_o, w[11] ? 9'h2 : w[10] ? 9'h1 : 9'h0);
			cmp(opcode_o, eop);
			cmp(faddr_o, w[11] ? 9'h0 : w[4:0]);
			cmp({dest_file_o, dest_acc_o}, !w[11:10] ? {w[5], !w[5]} : 2'h0);
			cmp(bit_mask_o, w[11:10] == 2'h1 ? 8'h01 << w[7:5] : 8'h00);
			cmp(bit_sel_o, w[11:10] == 2'h1 ? w[7:5] : 3'h0);
			cmp(literal_o, jmp ? w[8:0] : w[11] ? w[7:0] : 9'h0);
			cmp(lit9_o, jmp);
			cmp(second_cyc_o, lng);
			cmp(phase_o, 9'h3);
			// Every word, the first after a reset too, ends four clocks on
			cmp(9'(n), 9'h4);
			if (lng)
			begin
				repeat (4) @(negedge sys_clk_i);
				cmp({fetch_o, second_cyc_o}, 9'h2);
			end
		end
	endtask : chk
	// Reset hits just after a cycle end; outputs clear, then a fresh start
	task automatic t_reset();
		rstn_i = 1'b0;
		@(negedge sys_clk_i);
		cmp({cat_o, fetch_o, second_cyc_o, lit9_o, phase_o, opcode_o[1:0]}, 9'h0);
		repeat (16) @(negedge sys_clk_i);
		rstn_i = 1'b1;
		idx = 0;
	endtask : t_reset
	// Byte words: both destinations, a PC file write, both count-and-skip tests
	task automatic t_byte();
		chk(12'h1E5, 1'b0, 1'b0);
		chk(12'h1C5, 1'b0, 1'b0);
		chk(12'h03F, 1'b0, 1'b0);
		chk(12'h022, 1'b0, 1'b1);
		chk(12'h1C2, 1'b0, 1'b0);
		chk(12'h2C3, 1'b0, 1'b0);
		chk(12'h2C3, 1'b1, 1'b1);
		chk(12'h3E0, 1'b1, 1'b1);
	endtask : t_byte
	// Condition true on a plain bit op must not stretch it
	task automatic t_bit();
		chk(12'h4FF, 1'b1, 1'b0);
		chk(12'h500, 1'b0, 1'b0);
		chk(12'h666, 1'b1, 1'b1);
		chk(12'h7E1, 1'b0, 1'b0);
	endtask : t_bit
	task automatic t_lit();
		chk(12'hCA5, 1'b0, 1'b0);
		chk(12'h9FF, 1'b0, 1'b1);
		chk(12'hBFF, 1'b0, 1'b1);
		chk(12'hA00, 1'b0, 1'b1);
		chk(12'h812, 1'b0, 1'b1);
	endtask : t_lit
	initial
	begin
		t_reset();
		t_byte();
		t_bit();
		t_reset();
		t_lit();
		conclude();
	end
endmodule : tbd_decode_tb
